// File: hdl/tmr_params.svh
// register offsets, field positions and reset values of the 16-bit timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_OFF_CMPA_LO   8'h30
`define TMR_OFF_CMPA_HI   8'h31
`define TMR_OFF_CMPB_LO   8'h32
`define TMR_OFF_CMPB_HI   8'h33
`define TMR_OFF_CAPA_LO   8'h34
`define TMR_OFF_CAPA_HI   8'h35
`define TMR_OFF_CAPB_LO   8'h36
`define TMR_OFF_CAPB_HI   8'h37
`define TMR_OFF_MODE      8'h38
`define TMR_OFF_TOGGLE    8'h39
`define TMR_OFF_RUN       8'h3a
`define TMR_OFF_TRIG      8'h3b
`define TMR_OFF_SYSCLK    8'h3c
`define TMR_MODE_RESET    8'h20
`define TMR_TOGGLE_RESET  8'h03
`define TMR_TRIG_ONES     8'h70
`define TMR_PRE_DIV       2'd3
`define TMR_PRE_WIDTH     9
`define TMR_TAP_T1        3'd0
`define TMR_TAP_T4        3'd2
`define TMR_TAP_T16       3'd4
`endif

// File: hdl/tmr_pkg.sv
// types of the 16-bit timer
package tmr_pkg;
   typedef enum logic [1:0] {TMR_SRC_FPH = 2'b00, TMR_SRC_SLOW = 2'b01, TMR_SRC_FC16 = 2'b10} tmr_src_e;
   typedef enum logic [1:0] {TMR_CLK_PIN = 2'b00, TMR_CLK_T1 = 2'b01, TMR_CLK_T4 = 2'b10,
                             TMR_CLK_T16 = 2'b11} tmr_clk_e;
   typedef enum logic [1:0] {TMR_CAP_OFF = 2'b00, TMR_CAP_PINS = 2'b01, TMR_CAP_WIDTH = 2'b10,
                             TMR_CAP_TFF = 2'b11} tmr_cap_e;
   typedef struct packed
   {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmr_bus_s;
   typedef struct packed
   {
      logic fph;
      logic fc16;
      logic slow;
   } tmr_srcclk_s;
endpackage

// File: hdl/tmr_timer16.sv
// 16-bit timer/event counter with capture and compare
// Summary of operation
// [R1] selected source tick divided by four feeds the nine-bit prescaler
// [R2] reset selects the high-speed peripheral tick as prescaler source
// [R3] counter internal ticks are prescaler taps of source over 8, 32, 128
// [R4] prescaler run bit starts it; clearing stops and zeroes; reset clears it
// [R5] clock select picks a tap or external pin rising edge; reset picks pin
// [R6] counter run bit counts when set, stops and zeroes when clear
// [R7] with match-clear enabled the counter clears on compare b match only
// [R8] both compare values are watched continuously, each raising its own irq
// [R9] software writes compare values whole, low byte first
// [R10] double-buffer enable is off at reset, on when one
// [R11] buffered compare a loads from its buffer on compare b match
// [R12] compare a write updates value and buffer, or only buffer when buffered
// [R13] software reads capture values whole, low byte first
// [R14] capture mode 00 disables hardware capture, and is the reset mode
// [R15] mode 01 captures a on count pin rise, b on second pin rise
// [R16] mode 10 captures a on pin rise, b on fall; pin irq on fall too
// [R17] mode 11 captures a and b on eight-bit timer toggle rise and fall
// [R18] writing zero to soft capture bit captures counter into capture a
// [R19] trigger control bits 6 to 4 always read as one
// [R20] software should stop the prescaler before oscillator-only idle
// [R21] software must not pick fc/16 source while slow clock is system clock
// [R22] output toggle inverts on enabled matches and captures
// [R23] toggle code 00 inverts, 01 sets, 10 clears the output toggle
// [R24] free-running counter wraps from all ones to zero
`include "tmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16
   import tmr_pkg::*;
#(
   parameter int PRE_WIDTH = `TMR_PRE_WIDTH
)
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   // register port
   input  wire tmr_bus_s    bus_i,
   output logic [7:0]       rdata_o,
   // source tick enables
   input  wire tmr_srcclk_s src_tick_i,
   // pins
   input  wire logic        ext_count_pin_i,
   input  wire logic        second_trigger_pin_i,
   input  wire logic        eight_bit_timer_toggle_i,
   // events
   output logic             compare_a_irq_o,
   output logic             compare_b_irq_o,
   output logic             trigger_pin_irq_o,
   output logic             output_toggle_o
);
   // registers
   logic [15:0]          compare_a_value, compare_a_buf, compare_b_value;
   logic [15:0]          capture_a_value, capture_b_value, up_counter;
   logic [7:0]           timer_mode_reg, toggle_control_reg, run_control_reg, trigger_control_reg;
   logic [7:0]           system_clock_reg, cmp_lo_hold, cap_hi_hold;
   logic [1:0]           pre_div;
   logic [PRE_WIDTH-1:0] prescaler;
   logic                 pin_q, trig2_q, tff_q, output_toggle, tap_t1, tap_t4, tap_t16;
   logic [PRE_WIDTH-1:0] tap_q;
   logic [15:0]          next_compare_a_value, next_compare_a_buf, next_compare_b_value;
   logic [15:0]          next_capture_a_value, next_capture_b_value, next_up_counter;
   logic [7:0]           next_timer_mode_reg, next_toggle_control_reg, next_run_control_reg;
   logic [7:0]           next_trigger_control_reg, next_system_clock_reg, next_cmp_lo_hold;
   logic [7:0]           next_cap_hi_hold, next_rdata;
   logic [1:0]           next_pre_div;
   logic [PRE_WIDTH-1:0] next_prescaler;
   logic                 next_output_toggle;
   // decoded fields
   logic                 prescaler_run_bit, counter_run_bit, double_buffer_enable, clear_enable;
   tmr_src_e             prescaler_source_sel;
   tmr_clk_e             counter_clock_sel;
   tmr_cap_e             capture_mode_sel;
   logic                 src_tick, count_tick, match_a, match_b, cap_a_ev, cap_b_ev;
   logic                 pin_rise, pin_fall, trig2_rise, tff_rise, tff_fall, wr_mode;

   // address compare used by every register write
   function automatic logic hit(input tmr_bus_s b, input logic [7:0] off);
      hit = b.write && (b.addr == off);
   endfunction

   assign prescaler_run_bit    = run_control_reg[7];
   assign counter_run_bit      = run_control_reg[4];
   assign prescaler_source_sel = tmr_src_e'(system_clock_reg[1:0]);
   assign counter_clock_sel    = tmr_clk_e'(timer_mode_reg[1:0]);
   assign clear_enable         = timer_mode_reg[2];
   assign capture_mode_sel     = tmr_cap_e'(timer_mode_reg[4:3]);
   assign double_buffer_enable = trigger_control_reg[7];
   assign wr_mode              = hit(bus_i, `TMR_OFF_MODE);

   // source select then fixed divide by four; fc16 under slow system clock is a software hazard
   always_comb
   begin
      case (prescaler_source_sel)
         TMR_SRC_FPH:  src_tick = src_tick_i.fph;  // [R2]
         TMR_SRC_SLOW: src_tick = src_tick_i.slow;
         TMR_SRC_FC16: src_tick = src_tick_i.fc16; // [R21]
         default:      src_tick = src_tick_i.fph;
      endcase
      next_pre_div   = pre_div;
      next_prescaler = prescaler;
      if (!prescaler_run_bit)
      begin
         next_pre_div   = 2'd0; // [R4]
         next_prescaler = '0;
      end
      else if (src_tick)
      begin
         next_pre_div = pre_div + 2'd1; // [R1]
         if (pre_div == `TMR_PRE_DIV)
         begin
            next_prescaler = prescaler + 1'b1; // [R1]
         end
      end
   end

   // tap ticks: rising edge of prescaler bits 0, 2 and 4
   genvar gi;
   generate
      for (gi = 0; gi < PRE_WIDTH; gi++)
      begin : g_tap
         always_ff @(posedge core_clk_i)
         begin
            if (!reset_n_i)
               tap_q[gi] <= 1'b0;
            else
               tap_q[gi] <= prescaler[gi];
         end
      end
   endgenerate
   assign tap_t1  = prescaler[`TMR_TAP_T1]  & ~tap_q[`TMR_TAP_T1];  // [R3]
   assign tap_t4  = prescaler[`TMR_TAP_T4]  & ~tap_q[`TMR_TAP_T4];  // [R3]
   assign tap_t16 = prescaler[`TMR_TAP_T16] & ~tap_q[`TMR_TAP_T16]; // [R3]

   assign pin_rise   = ext_count_pin_i & ~pin_q;
   assign pin_fall   = ~ext_count_pin_i & pin_q;
   assign trig2_rise = second_trigger_pin_i & ~trig2_q;
   assign tff_rise   = eight_bit_timer_toggle_i & ~tff_q;
   assign tff_fall   = ~eight_bit_timer_toggle_i & tff_q;

   // counter, compare, capture
   always_comb
   begin
      case (counter_clock_sel)
         TMR_CLK_PIN: count_tick = pin_rise; // [R5]
         TMR_CLK_T1:  count_tick = tap_t1;   // [R5]
         TMR_CLK_T4:  count_tick = tap_t4;
         TMR_CLK_T16: count_tick = tap_t16;
         default:     count_tick = 1'b0;
      endcase
      // a stopped counter sits at zero and must not match
      match_a = (up_counter == compare_a_value) && count_tick && counter_run_bit; // [R8]
      match_b = (up_counter == compare_b_value) && count_tick && counter_run_bit; // [R8]
      next_up_counter = up_counter;
      if (!counter_run_bit)
         next_up_counter = 16'h0000; // [R6]
      else if (match_b && clear_enable)
         next_up_counter = 16'h0000; // [R7]
      else if (count_tick)
         next_up_counter = up_counter + 16'h0001; // [R24]
      case (capture_mode_sel)
         TMR_CAP_PINS:
         begin
            cap_a_ev = pin_rise;   // [R15]
            cap_b_ev = trig2_rise; // [R15]
         end
         TMR_CAP_WIDTH:
         begin
            cap_a_ev = pin_rise; // [R16]
            cap_b_ev = pin_fall; // [R16]
         end
         TMR_CAP_TFF:
         begin
            cap_a_ev = tff_rise; // [R17]
            cap_b_ev = tff_fall; // [R17]
         end
         default:
         begin
            cap_a_ev = 1'b0; // [R14]
            cap_b_ev = 1'b0;
         end
      endcase
      next_capture_a_value = capture_a_value;
      next_capture_b_value = capture_b_value;
      if (cap_a_ev || (wr_mode && !bus_i.wdata[5])) // [R18]
         next_capture_a_value = up_counter;
      if (cap_b_ev)
         next_capture_b_value = up_counter;
   end

   // register writes; 16-bit values commit on the high byte so halves never mix
   always_comb
   begin
      next_compare_a_value     = compare_a_value;
      next_compare_a_buf       = compare_a_buf;
      next_compare_b_value     = compare_b_value;
      next_cmp_lo_hold         = cmp_lo_hold;
      next_cap_hi_hold         = cap_hi_hold;
      next_timer_mode_reg      = timer_mode_reg;
      next_toggle_control_reg  = toggle_control_reg;
      next_run_control_reg     = run_control_reg;
      next_trigger_control_reg = trigger_control_reg;
      next_system_clock_reg    = system_clock_reg;
      next_output_toggle       = output_toggle;
      next_rdata               = 8'h00;
      if (hit(bus_i, `TMR_OFF_CMPA_LO) || hit(bus_i, `TMR_OFF_CMPB_LO))
         next_cmp_lo_hold = bus_i.wdata; // [R9]
      if (match_b && double_buffer_enable)
         next_compare_a_value = compare_a_buf; // [R11]
      if (hit(bus_i, `TMR_OFF_CMPA_HI))
      begin
         next_compare_a_buf = {bus_i.wdata, cmp_lo_hold}; // [R12]
         if (!double_buffer_enable)
            next_compare_a_value = {bus_i.wdata, cmp_lo_hold}; // [R12]
      end
      if (hit(bus_i, `TMR_OFF_CMPB_HI))
         next_compare_b_value = {bus_i.wdata, cmp_lo_hold}; // [R9]
      if (wr_mode)
         next_timer_mode_reg = bus_i.wdata | 8'h20;
      if (hit(bus_i, `TMR_OFF_RUN))
         next_run_control_reg = bus_i.wdata; // [R20]
      if (hit(bus_i, `TMR_OFF_TRIG))
         next_trigger_control_reg = bus_i.wdata; // [R10]
      if (hit(bus_i, `TMR_OFF_SYSCLK))
         next_system_clock_reg = bus_i.wdata;
      if ((match_a && toggle_control_reg[2]) || (match_b && toggle_control_reg[3])
          || (cap_a_ev && toggle_control_reg[4]) || (cap_b_ev && toggle_control_reg[5]))
         next_output_toggle = ~next_output_toggle; // [R22]
      if (hit(bus_i, `TMR_OFF_TOGGLE))
      begin
         next_toggle_control_reg = bus_i.wdata | 8'h03;
         case (bus_i.wdata[1:0])
            2'b00:   next_output_toggle = ~output_toggle; // [R23]
            2'b01:   next_output_toggle = 1'b1;           // [R23]
            2'b10:   next_output_toggle = 1'b0;           // [R23]
            default: next_output_toggle = next_output_toggle;
         endcase
      end
      if (bus_i.read)
      begin
         case (bus_i.addr)
            `TMR_OFF_CMPA_LO: next_rdata = compare_a_value[7:0];
            `TMR_OFF_CMPA_HI: next_rdata = compare_a_value[15:8];
            `TMR_OFF_CMPB_LO: next_rdata = compare_b_value[7:0];
            `TMR_OFF_CMPB_HI: next_rdata = compare_b_value[15:8];
            `TMR_OFF_CAPA_LO:
            begin
               next_rdata       = capture_a_value[7:0]; // [R13]
               next_cap_hi_hold = capture_a_value[15:8];
            end
            `TMR_OFF_CAPA_HI: next_rdata = cap_hi_hold; // [R13]
            `TMR_OFF_CAPB_LO:
            begin
               next_rdata       = capture_b_value[7:0];
               next_cap_hi_hold = capture_b_value[15:8];
            end
            `TMR_OFF_CAPB_HI: next_rdata = cap_hi_hold;
            `TMR_OFF_MODE:    next_rdata = timer_mode_reg;
            `TMR_OFF_TOGGLE:  next_rdata = {toggle_control_reg[7:2], 1'b1, output_toggle};
            `TMR_OFF_RUN:     next_rdata = run_control_reg;
            `TMR_OFF_TRIG:    next_rdata = trigger_control_reg | `TMR_TRIG_ONES; // [R19]
            `TMR_OFF_SYSCLK:  next_rdata = system_clock_reg;
            default:          next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         compare_a_value     <= 16'h0000;
         compare_a_buf       <= 16'h0000;
         compare_b_value     <= 16'h0000;
         capture_a_value     <= 16'h0000;
         capture_b_value     <= 16'h0000;
         up_counter          <= 16'h0000;
         cmp_lo_hold         <= 8'h00;
         cap_hi_hold         <= 8'h00;
         timer_mode_reg      <= `TMR_MODE_RESET; // [R5] [R14]
         toggle_control_reg  <= `TMR_TOGGLE_RESET;
         run_control_reg     <= 8'h00;           // [R4]
         trigger_control_reg <= 8'h00;           // [R10]
         system_clock_reg    <= 8'h00;           // [R2]
         pre_div             <= 2'd0;
         prescaler           <= '0;
         output_toggle       <= 1'b0;
         pin_q               <= 1'b0;
         trig2_q             <= 1'b0;
         tff_q               <= 1'b0;
         rdata_o             <= 8'h00;
         compare_a_irq_o     <= 1'b0;
         compare_b_irq_o     <= 1'b0;
         trigger_pin_irq_o   <= 1'b0;
      end
      else
      begin
         compare_a_value     <= next_compare_a_value;
         compare_a_buf       <= next_compare_a_buf;
         compare_b_value     <= next_compare_b_value;
         capture_a_value     <= next_capture_a_value;
         capture_b_value     <= next_capture_b_value;
         up_counter          <= next_up_counter;
         cmp_lo_hold         <= next_cmp_lo_hold;
         cap_hi_hold         <= next_cap_hi_hold;
         timer_mode_reg      <= next_timer_mode_reg;
         toggle_control_reg  <= next_toggle_control_reg;
         run_control_reg     <= next_run_control_reg;
         trigger_control_reg <= next_trigger_control_reg;
         system_clock_reg    <= next_system_clock_reg;
         pre_div             <= next_pre_div;
         prescaler           <= next_prescaler;
         output_toggle       <= next_output_toggle;
         pin_q               <= ext_count_pin_i;
         trig2_q             <= second_trigger_pin_i;
         tff_q               <= eight_bit_timer_toggle_i;
         rdata_o             <= next_rdata;
         compare_a_irq_o     <= match_a; // [R8]
         compare_b_irq_o     <= match_b; // [R8]
         trigger_pin_irq_o   <= pin_rise || (pin_fall && capture_mode_sel == TMR_CAP_WIDTH); // [R16]
      end
   end

   assign output_toggle_o = output_toggle;
endmodule
`default_nettype wire

// File: testbench/tmr_timer16_properties.sv
// concurrent checks on the ports of the 16-bit timer
`include "tmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_checker
   import tmr_pkg::*;
#(
   parameter int PRE_WIDTH = `TMR_PRE_WIDTH
)
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   // register port
   input  wire tmr_bus_s    bus_i,
   input  wire logic [7:0]  rdata_o,
   // ticks and pins
   input  wire tmr_srcclk_s src_tick_i,
   input  wire logic        ext_count_pin_i,
   input  wire logic        second_trigger_pin_i,
   input  wire logic        eight_bit_timer_toggle_i,
   // events
   input  wire logic        compare_a_irq_o,
   input  wire logic        compare_b_irq_o,
   input  wire logic        trigger_pin_irq_o,
   input  wire logic        output_toggle_o
);
   logic [4:0] mode_q;
   logic       db_q;
   logic       run_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // shadow of the written control fields, reset as the design resets
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         mode_q <= 5'h00;
         db_q   <= 1'b0;
         run_q  <= 1'b0;
      end
      else if (bus_i.write)
      begin
         if (bus_i.addr == `TMR_OFF_MODE) mode_q <= bus_i.wdata[4:0];
         if (bus_i.addr == `TMR_OFF_TRIG) db_q <= bus_i.wdata[7];
         if (bus_i.addr == `TMR_OFF_RUN) run_q <= bus_i.wdata[4];
      end
   end
   rdata_idle_a: assert property (!$past(bus_i.read) |-> rdata_o == 8'h00)
      else $error("read data not idle");
   trig_read_a: assert property ($past(bus_i.read) && $past(bus_i.addr) == `TMR_OFF_TRIG
      |-> rdata_o == {db_q, 7'h70}) else $error("trigger register readback wrong");
   mode_read_a: assert property ($past(bus_i.read) && $past(bus_i.addr) == `TMR_OFF_MODE
      |-> rdata_o[5:0] == {1'b1, mode_q}) else $error("mode register readback wrong");
   irq_pulse_a: assert property (compare_a_irq_o || compare_b_irq_o
      |=> !compare_a_irq_o && !compare_b_irq_o) else $error("compare irq longer than one cycle");
   stop_quiet_a: assert property (!run_q && $past(!run_q)
      |=> !compare_a_irq_o && !compare_b_irq_o) else $error("compare irq while counter stopped");
   pin_rise_a: assert property ($rose(ext_count_pin_i) |-> ##[1:3] trigger_pin_irq_o)
      else $error("no pin irq on rise");
   pin_fall_a: assert property ($fell(ext_count_pin_i) && mode_q[4:3] == 2'b10
      |-> ##[1:3] trigger_pin_irq_o) else $error("no pin irq on fall in width mode");
   tff_set_a: assert property (bus_i.write && bus_i.addr == `TMR_OFF_TOGGLE && bus_i.wdata[5:0] == 6'h01
      |=> output_toggle_o) else $error("output toggle not set");
   tff_clr_a: assert property (bus_i.write && bus_i.addr == `TMR_OFF_TOGGLE && bus_i.wdata[5:0] == 6'h02
      |=> !output_toggle_o) else $error("output toggle not cleared");
   tff_inv_a: assert property (bus_i.write && bus_i.addr == `TMR_OFF_TOGGLE && bus_i.wdata[5:0] == 6'h00
      |=> output_toggle_o != $past(output_toggle_o)) else $error("output toggle not inverted");
   cover property (compare_b_irq_o);
   cover property (trigger_pin_irq_o && mode_q[4:3] == 2'b10);
   cover property (compare_a_irq_o && db_q);
endmodule
bind tmr_timer16 tmr_timer16_checker #(.PRE_WIDTH(PRE_WIDTH)) i_tmr_timer16_checker (.core_clk_i, .reset_n_i,
   .bus_i, .rdata_o, .src_tick_i, .ext_count_pin_i, .second_trigger_pin_i, .eight_bit_timer_toggle_i,
   .compare_a_irq_o, .compare_b_irq_o, .trigger_pin_irq_o, .output_toggle_o);
`default_nettype wire

// File: testbench/tmr_pin_model.sv
// pin-side partner: count pin, second trigger pin and eight-bit timer toggle
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model
(
   // clock and requests
   input  wire logic       core_clk_i,
   input  wire logic [2:0] go_i,
   // pins
   output logic            ext_count_pin_o,
   output logic            second_trigger_pin_o,
   output logic            eight_bit_timer_toggle_o
);
   int hold_a = 0;
   int hold_b = 0;
   initial
   begin
      ext_count_pin_o = 1'b0;
      second_trigger_pin_o = 1'b0;
      eight_bit_timer_toggle_o = 1'b0;
   end
   // pulses stay high four cycles so no edge detector can miss them
   always @(posedge core_clk_i)
   begin
      hold_a <= go_i[0] ? 4 : (hold_a > 0 ? hold_a - 1 : 0);
      hold_b <= go_i[1] ? 4 : (hold_b > 0 ? hold_b - 1 : 0);
      ext_count_pin_o <= go_i[0] || hold_a > 1;
      second_trigger_pin_o <= go_i[1] || hold_b > 1;
      if (go_i[2]) eight_bit_timer_toggle_o <= ~eight_bit_timer_toggle_o;
   end
endmodule
`default_nettype wire

// File: testbench/tb_tmr_timer16.sv
// self-checking bench of the 16-bit timer
`include "tmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_tmr_timer16
   import tmr_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n;
   tmr_bus_s    bus;
   tmr_srcclk_s ticks;
   logic [7:0]  rdata;
   logic [2:0]  go;
   logic        pin_a, pin_b, tff, irq_a, irq_b, irq_p, tog;
   int          num_errors = 0;
   int          checks = 0;
   int          na = 0;
   int          nb = 0;
   int          cyc = 0;
   int          t0, t1, a0, b0;
   logic [7:0]  tcode [4] = '{8'h01, 8'h02, 8'h00, 8'h00};
   logic        texp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ticks <= '{1'b1, cyc[0], cyc[1] & cyc[0]};
      if (irq_a === 1'b1) na <= na + 1;
      if (irq_b === 1'b1) nb <= nb + 1;
   end
   tmr_timer16 i_tmr_timer16 (.core_clk_i(clk), .reset_n_i(reset_n), .bus_i(bus), .rdata_o(rdata),
      .src_tick_i(ticks), .ext_count_pin_i(pin_a), .second_trigger_pin_i(pin_b),
      .eight_bit_timer_toggle_i(tff), .compare_a_irq_o(irq_a), .compare_b_irq_o(irq_b),
      .trigger_pin_irq_o(irq_p), .output_toggle_o(tog));
   tmr_pin_model i_tmr_pin_model (.core_clk_i(clk), .go_i(go), .ext_count_pin_o(pin_a),
      .second_trigger_pin_o(pin_b), .eight_bit_timer_toggle_o(tff));
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", s, e, g);
         num_errors++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      d = rdata;
   endtask
   // whole values only, low byte first
   task wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask
   task chk16(input string s, input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v[7:0]);
      rd(a + 8'h01, v[15:8]);
      chk(s, e, v);
   endtask
   task chk_rd(input string s, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(s, {8'h00, e}, {8'h00, d});
   endtask
   task pulse(input int p, input int n);
      repeat (n)
      begin
         go[p] <= 1'b1;
         @(posedge clk);
         go[p] <= 1'b0;
         repeat (9) @(posedge clk);
      end
   endtask
   task wait_b(output int t);
      t = -1;
      for (int i = 0; i < 400 && t < 0; i++)
      begin
         @(posedge clk);
         if (irq_b === 1'b1) t = cyc;
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
   initial
   begin
      bus = '0;
      go = '0;
      ticks = '0;
      reset_n = 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk_rd("mode", `TMR_OFF_MODE, 8'h20);
      chk_rd("trigger", `TMR_OFF_TRIG, 8'h70);
      chk_rd("toggle ctrl", `TMR_OFF_TOGGLE, 8'h02);
      chk_rd("source", `TMR_OFF_SYSCLK, 8'h00);
      chk_rd("run", `TMR_OFF_RUN, 8'h00);
      chk_rd("unmapped", 8'h3f, 8'h00);
      $display("reset test done");
      wr16(`TMR_OFF_CMPB_LO, 16'h0003);
      wr(`TMR_OFF_MODE, 8'h25);
      wr(`TMR_OFF_RUN, 8'h10);
      wait_b(t0);
      chk("stopped prescaler", 16'h0001, 16'(t0 < 0));
      wr(`TMR_OFF_RUN, 8'h90);
      wait_b(t0);
      wait_b(t1);
      chk("match period", 16'd32, 16'(t1 - t0));
      // slow ticks every fourth cycle; first match after the switch is dropped as its spacing is mixed
      wr(`TMR_OFF_SYSCLK, 8'h01);
      wait_b(t0);
      wait_b(t0);
      wait_b(t1);
      chk("slow period", 16'd128, 16'(t1 - t0));
      wr(`TMR_OFF_SYSCLK, 8'h00);
      wr(`TMR_OFF_RUN, 8'h00);
      $display("prescaler test done");
      wr(`TMR_OFF_MODE, 8'h20);
      wr(`TMR_OFF_RUN, 8'h90);
      pulse(0, 5);
      pulse(2, 2);
      chk16("capture a off", `TMR_OFF_CAPA_LO, 16'd0);
      wr(`TMR_OFF_MODE, 8'h38);
      pulse(2, 1);
      pulse(0, 2);
      pulse(2, 1);
      chk16("capture a toggle", `TMR_OFF_CAPA_LO, 16'd5);
      chk16("capture b toggle", `TMR_OFF_CAPB_LO, 16'd7);
      pulse(0, 1);
      wr(`TMR_OFF_MODE, 8'h28);
      pulse(1, 1);
      chk16("capture b pin", `TMR_OFF_CAPB_LO, 16'd8);
      wr(`TMR_OFF_MODE, 8'h08);
      chk16("soft capture", `TMR_OFF_CAPA_LO, 16'd8);
      wr(`TMR_OFF_MODE, 8'h30);
      pulse(0, 1);
      chk16("capture b fall", `TMR_OFF_CAPB_LO, 16'd9);
      $display("capture test done");
      wr(`TMR_OFF_RUN, 8'h00);
      wr(`TMR_OFF_MODE, 8'h24);
      wr16(`TMR_OFF_CMPB_LO, 16'd5);
      wr16(`TMR_OFF_CMPA_LO, 16'd1);
      wr(`TMR_OFF_RUN, 8'h90);
      a0 = na;
      b0 = nb;
      pulse(0, 6);
      chk("irq a count", 16'd1, 16'(na - a0));
      chk("irq b count", 16'd1, 16'(nb - b0));
      wr(`TMR_OFF_TRIG, 8'h80);
      chk_rd("trigger", `TMR_OFF_TRIG, 8'hf0);
      wr16(`TMR_OFF_CMPA_LO, 16'd4);
      pulse(0, 3);
      chk("buffered write", 16'd2, 16'(na - a0));
      pulse(0, 3);
      chk("irq b count", 16'd2, 16'(nb - b0));
      pulse(0, 4);
      chk("buffer not early", 16'd2, 16'(na - a0));
      pulse(0, 1);
      chk("buffer loaded", 16'd3, 16'(na - a0));
      $display("double buffer test done");
      for (int i = 0; i < 4; i++)
      begin
         wr(`TMR_OFF_TOGGLE, tcode[i]);
         chk("output toggle", {15'h0000, texp[i]}, {15'h0000, tog});
      end
      // enable inversion on compare a only; counter sits at 5, so b clears it and a hits on the sixth tick
      wr(`TMR_OFF_TOGGLE, 8'h07);
      pulse(0, 6);
      chk("match toggle", 16'h0001, {15'h0000, tog});
      $display("toggle test done");
      results();
   end
endmodule
`default_nettype wire
